/* rtl/spc_pkg.sv */
// spc_pkg: constants for travel set-point conditioning and gain selection
// assumes fixed-point travel in hundredths of a percent, gains in hundredths or whole units
package spc_pkg;
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_OPEN_RATE   = 8'h00; // opening_rate_limit, 0.01 %/s
  localparam logic [7:0] OFS_CLOSE_RATE  = 8'h04; // closing_rate_limit, 0.01 %/s
  localparam logic [7:0] OFS_LAG_TIME    = 8'h08; // lag time constant, 0.1 s
  localparam logic [7:0] OFS_CUTOFF_CTRL = 8'h0C; // bit0 upper enable, bit1 lower enable
  localparam logic [7:0] OFS_UPPER_THR   = 8'h10; // upper_saturation_threshold, 0.01 %
  localparam logic [7:0] OFS_LOWER_THR   = 8'h14; // lower_saturation_threshold, 0.01 %
  localparam logic [7:0] OFS_TUNE_SEL    = 8'h18; // bits3:0 set, bits5:4 gain table
  localparam logic [7:0] OFS_PROP_GAIN   = 8'h1C; // proportional gain, 0.01
  localparam logic [7:0] OFS_VEL_GAIN    = 8'h20; // velocity gain, 0.01
  localparam logic [7:0] OFS_IFB_GAIN    = 8'h24; // inner_loop_feedback_gain, 1
  localparam logic [7:0] OFS_CMD         = 8'h28; // bit0 stabilize/optimize
  localparam logic [7:0] OFS_SETPOINT    = 8'h2C; // raw set point in, 0.01 %
  localparam logic [7:0] OFS_TARGET      = 8'h30; // travel target out (read only)
  localparam logic [7:0] OFS_TRAVEL      = 8'h34; // measured travel (read only)

  // field positions
  localparam int CUT_UPPER_BIT = 0;
  localparam int CUT_LOWER_BIT = 1;
  localparam int CMD_STAB_BIT  = 0;
  localparam int SEL_TABLE_LSB = 4;

  // travel scale: hundredths of a percent, signed 16 bit
  localparam int TRAVEL_W = 16;
  localparam logic signed [15:0] TARGET_HIGH_SAT = 16'sh300C; // +123.00 %
  localparam logic signed [15:0] TARGET_LOW_SAT  = -16'sh08FC; // -23.00 %
  localparam logic [15:0] THR_RESET     = 16'h1388; // 50.00 % recommended
  localparam logic [7:0]  LAG_MIN       = 8'h02;    // 0.2 s
  localparam logic [7:0]  LAG_MAX       = 8'h64;    // 10.0 s

  // update timing at 20 MHz clock
  localparam int CLK_HZ        = 20_000_000;
  localparam int UPDATE_HZ     = 100;              // control updates per second
  localparam int UPDATE_CYCLES = CLK_HZ / UPDATE_HZ;

  // tuning selections: C..M are 0..10, expert is 15
  localparam logic [3:0] SET_C      = 4'h0;
  localparam logic [3:0] SET_M      = 4'hA;
  localparam logic [3:0] SET_EXPERT = 4'hF;
  localparam logic [3:0] SET_RESET  = SET_C;

  typedef enum logic [1:0] {
    TBL_RELAY    = 2'h0,
    TBL_HF_ONE   = 2'h1,
    TBL_HF_TWO3  = 2'h2
  } gain_table_t;
endpackage : spc_pkg

/* rtl/gain_presets.sv */
// gain_presets: combinational lookup of preset controller gains
// assumes set index 0..10 for C..M; proportional and velocity gains in hundredths
`timescale 1ns/100ps
`default_nettype none
module gain_presets
  import spc_pkg::*;
(
  input  wire logic [3:0]  set_idx,
  input  wire logic [1:0]  table_sel,
  output logic      [15:0] prop_gain,
  output logic      [15:0] vel_gain,
  output logic      [7:0]  ifb_gain,
  output logic             ifb_valid
);
  // per-table constants, slowest first
  localparam logic [15:0] RELAY_P [11] = '{16'h01B8, 16'h01E0, 16'h0226, 16'h026C, 16'h02D0,
    16'h0348, 16'h03CA, 16'h046A, 16'h051E, 16'h060E, 16'h0708};
  localparam logic [15:0] RELAY_V [11] = '{16'h012C, 16'h012C, 16'h012C, 16'h0136, 16'h0168,
    16'h01A4, 16'h01E5, 16'h0235, 16'h0258, 16'h0258, 16'h0258};
  localparam logic [7:0]  RELAY_F [11] = '{8'h23, 8'h23, 8'h23, 8'h23, 8'h22, 8'h1F, 8'h1B,
    8'h17, 8'h12, 8'h0C, 8'h0C};
  localparam logic [15:0] HF1_P [11] = '{16'h00AA, 16'h00E6, 16'h0122, 16'h0154, 16'h0190,
    16'h01CC, 16'h0208, 16'h0244, 16'h0276, 16'h02B2, 16'h02EE};
  localparam logic [15:0] HF1_V [11] = '{16'h0FA0, 16'h0E10, 16'h0CE4, 16'h0C80, 16'h0C1C,
    16'h0BB8, 16'h0B54, 16'h0B54, 16'h0AF0, 16'h0AF0, 16'h0A8C};
  localparam logic [15:0] HF2_P [11] = '{16'h00FA, 16'h014A, 16'h0190, 16'h01E0, 16'h0226,
    16'h0276, 16'h02BC, 16'h030C, 16'h0352, 16'h03A2, 16'h03E8};
  localparam logic [15:0] HF2_V [11] = '{16'h0E74, 16'h0D48, 16'h0C80, 16'h0C1C, 16'h0C1C,
    16'h0BB8, 16'h0BB8, 16'h0B54, 16'h0B54, 16'h0B54, 16'h0AF0};

  logic [3:0] idx;
  // clamp out-of-range index to fastest set
  assign idx = (set_idx > SET_M) ? SET_M : set_idx;

  // table select; high-flow tables carry no inner-loop gain
  always_comb begin
    prop_gain = RELAY_P[idx];
    vel_gain  = RELAY_V[idx];
    ifb_gain  = RELAY_F[idx];
    ifb_valid = 1'b1;
    if (table_sel == TBL_HF_ONE) begin
      prop_gain = HF1_P[idx];
      vel_gain  = HF1_V[idx];
      ifb_gain  = 8'h00;
      ifb_valid = 1'b0;
    end else if (table_sel == TBL_HF_TWO3) begin
      prop_gain = HF2_P[idx];
      vel_gain  = HF2_V[idx];
      ifb_gain  = 8'h00;
      ifb_valid = 1'b0;
    end
  end
endmodule : gain_presets
`default_nettype wire

/* rtl/lag_filter.sv */
// lag_filter: first-order lag on the set point, one step per update tick
// assumes lag time in tenths of a second and a fixed update rate
`timescale 1ns/100ps
`default_nettype none
module lag_filter
  import spc_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                tick,
  input  wire logic [7:0]          lag_time,
  input  wire logic signed [15:0]  sp_in,
  output logic      signed [15:0]  sp_out
);
  logic signed [15:0] y_q;
  logic signed [31:0] diff;
  logic [15:0]        div;
  logic signed [31:0] step;
  logic signed [15:0] y_d;

  // updates per time constant: lag_time * UPDATE_HZ / 10
  assign div  = 16'(({8'h00, lag_time} * 16'(UPDATE_HZ)) / 16'd10);
  assign diff = 32'(sp_in) - 32'(y_q);
  assign step = (div == 16'h0000) ? diff : diff / $signed({16'h0000, div});
  assign y_d  = 16'(32'(y_q) + step);

  // filter state follows input directly when disabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      y_q <= 16'sh0000;
    end else if (lag_time == 8'h00) begin
      y_q <= sp_in;
    end else if (tick) begin
      y_q <= y_d;
    end
  end

  // on an update the next state is passed on, so the rate limiter acts after the lag step
  assign sp_out = (lag_time == 8'h00) ? sp_in : (tick ? y_d : y_q);
endmodule : lag_filter
`default_nettype wire

/* rtl/setpoint_conditioner.sv */
// setpoint_conditioner: rate limits, lag filter, cutoff override and gain selection
// assumes a simple strobe register port on clk; measured travel from same clock domain
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - opening moves limited to opening rate per second; zero means no limit
// - closing moves limited to closing rate per second; zero means no limit
// - optional lag filter with time constant 0.2 to 10.0 seconds
// - lag time of zero bypasses the filter completely
// - upper cutoff enabled and travel above threshold forces target to 123 percent
// - lower cutoff enabled and travel below threshold forces target to minus 23 percent
// - upper threshold is within travel range, cutoff active above it, 50 percent default
// - lower threshold is within travel range, cutoff active below it, 50 percent default
// - eleven preset tuning sets each give a fixed group of gains
// - presets ordered slowest C through fastest M
// - standard relay presets supply proportional, velocity and inner-loop gains
// - high-flow tables supply proportional and velocity gains only
// - expert selection uses individually written gains
// - writing any gain or running stabilize switches selection to expert
module setpoint_conditioner
  import spc_pkg::*;
#(
  parameter int UPD_CYCLES = UPDATE_CYCLES
)(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic [15:0] travel,
  output logic      [15:0] travel_target,
  output logic      [15:0] prop_gain,
  output logic      [15:0] vel_gain,
  output logic      [7:0]  inner_loop_feedback_gain,
  output logic             update_pulse
);
  // configuration registers
  logic [15:0] opening_rate_limit_q;
  logic [15:0] closing_rate_limit_q;
  logic [7:0]  lag_time_q;
  logic [1:0]  cutoff_en_q;
  logic [15:0] upper_saturation_threshold_q;
  logic [15:0] lower_saturation_threshold_q;
  logic [3:0]  tune_set_q;
  logic [1:0]  table_q;
  logic [15:0] exp_prop_q;
  logic [15:0] exp_vel_q;
  logic [7:0]  exp_ifb_q;
  logic [15:0] setpoint_q;
  logic [15:0] rate_sp_q;
  logic [15:0] target_q;
  logic [31:0] rdata_q;
  logic [31:0] upd_cnt_q;
  logic        tick_q;
  logic [15:0] prop_q;
  logic [15:0] vel_q;
  logic [7:0]  ifb_q;

  logic [15:0] pre_p;
  logic [15:0] pre_v;
  logic [7:0]  pre_f;
  logic        pre_f_valid;
  logic [15:0] filt_sp;

  // write decode helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : hit

  // gains that a single gain write leaves alone: the expert copies once in expert,
  // otherwise the preset lookup, which already follows a selection written just before;
  // taking them from the output flops would lose a gain written on the previous cycle
  logic [15:0] seed_p;
  logic [15:0] seed_v;
  logic [7:0]  seed_f;
  assign seed_p = (tune_set_q == SET_EXPERT) ? exp_prop_q : pre_p;
  assign seed_v = (tune_set_q == SET_EXPERT) ? exp_vel_q : pre_v;
  assign seed_f = (tune_set_q == SET_EXPERT) ? exp_ifb_q : (pre_f_valid ? pre_f : 8'h00);

  // update tick generator
  // one pulse every UPD_CYCLES clocks paces the whole update path
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      upd_cnt_q <= 32'h0000_0000;
      tick_q    <= 1'b0;
    end else if (upd_cnt_q == 32'(UPD_CYCLES - 1)) begin
      upd_cnt_q <= 32'h0000_0000;
      tick_q    <= 1'b1;
    end else begin
      upd_cnt_q <= upd_cnt_q + 32'h0000_0001;
      tick_q    <= 1'b0;
    end
  end

  // rate, lag, cutoff and set-point registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opening_rate_limit_q         <= 16'h0000;
      closing_rate_limit_q         <= 16'h0000;
      lag_time_q                   <= 8'h00;
      cutoff_en_q                  <= 2'h0;
      upper_saturation_threshold_q <= THR_RESET;
      lower_saturation_threshold_q <= THR_RESET;
      setpoint_q                   <= 16'h0000;
    end else if (wr) begin
      if (hit(addr, OFS_OPEN_RATE)) begin
        opening_rate_limit_q <= wdata[15:0];
      end
      if (hit(addr, OFS_CLOSE_RATE)) begin
        closing_rate_limit_q <= wdata[15:0];
      end
      if (hit(addr, OFS_CUTOFF_CTRL)) begin
        cutoff_en_q <= wdata[1:0];
      end
      if (hit(addr, OFS_UPPER_THR)) begin
        upper_saturation_threshold_q <= wdata[15:0];
      end
      if (hit(addr, OFS_LOWER_THR)) begin
        lower_saturation_threshold_q <= wdata[15:0];
      end
      if (hit(addr, OFS_SETPOINT)) begin
        setpoint_q <= wdata[15:0];
      end
      // lag time clamped to its legal span, zero kept as off; the upper bits are
      // tested first so a large value with a zero low byte never turns the filter off
      if (hit(addr, OFS_LAG_TIME)) begin
        if (wdata[31:8] != 24'h0 || wdata[7:0] > LAG_MAX) begin
          lag_time_q <= LAG_MAX;
        end else if (wdata[7:0] == 8'h00) begin
          lag_time_q <= 8'h00;
        end else if (wdata[7:0] < LAG_MIN) begin
          lag_time_q <= LAG_MIN;
        end else begin
          lag_time_q <= wdata[7:0];
        end
      end
    end
  end

  // tuning selection and expert gains
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tune_set_q <= SET_RESET;
      table_q    <= TBL_RELAY;
      exp_prop_q <= 16'h0000;
      exp_vel_q  <= 16'h0000;
      exp_ifb_q  <= 8'h00;
    end else if (wr) begin
      if (hit(addr, OFS_TUNE_SEL)) begin
        table_q <= wdata[SEL_TABLE_LSB +: 2];
        // an expert pick seeds the expert copies with the gains in force,
        // so a later single gain write keeps the other two
        if (wdata[3:0] <= SET_M) begin
          tune_set_q <= wdata[3:0];
        end else begin
          tune_set_q <= SET_EXPERT;
          exp_prop_q <= seed_p;
          exp_vel_q  <= seed_v;
          exp_ifb_q  <= seed_f;
        end
      end
      // any gain write or stabilize request forces expert, keeping unwritten gains
      if (hit(addr, OFS_PROP_GAIN) || hit(addr, OFS_VEL_GAIN) || hit(addr, OFS_IFB_GAIN)
          || (hit(addr, OFS_CMD) && wdata[CMD_STAB_BIT])) begin
        tune_set_q <= SET_EXPERT;
        exp_prop_q <= hit(addr, OFS_PROP_GAIN) ? wdata[15:0] : seed_p;
        exp_vel_q  <= hit(addr, OFS_VEL_GAIN) ? wdata[15:0] : seed_v;
        exp_ifb_q  <= hit(addr, OFS_IFB_GAIN) ? wdata[7:0] : seed_f;
      end
    end
  end

  gain_presets u_presets (
    .set_idx   (tune_set_q),
    .table_sel (table_q),
    .prop_gain (pre_p),
    .vel_gain  (pre_v),
    .ifb_gain  (pre_f),
    .ifb_valid (pre_f_valid)
  );

  // gain outputs follow preset or expert values
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prop_q <= 16'h0000;
      vel_q  <= 16'h0000;
      ifb_q  <= 8'h00;
    end else if (tune_set_q == SET_EXPERT) begin
      prop_q <= exp_prop_q;
      vel_q  <= exp_vel_q;
      ifb_q  <= exp_ifb_q;
    end else begin
      prop_q <= pre_p;
      vel_q  <= pre_v;
      ifb_q  <= pre_f_valid ? pre_f : 8'h00;
    end
  end

  lag_filter u_lag (
    .clk      (clk),
    .arst_n   (arst_n),
    .tick     (tick_q),
    .lag_time (lag_time_q),
    .sp_in    (setpoint_q),
    .sp_out   (filt_sp)
  );

  // per-update step from rate in 0.01 %/s
  function automatic logic signed [31:0] rate_step(input logic [15:0] rate);
    logic [31:0] s;
    s = 32'(rate) / 32'(UPDATE_HZ);
    return (s == 32'h0) ? 32'sh1 : $signed(s);
  endfunction : rate_step

  // rate limiter on the filtered set point, then cutoff override
  logic signed [31:0] delta;
  logic signed [15:0] limited;
  always_comb begin
    delta   = 32'($signed(filt_sp)) - 32'($signed(rate_sp_q));
    limited = filt_sp;
    if (delta > 0 && opening_rate_limit_q != 16'h0000
        && delta > rate_step(opening_rate_limit_q)) begin
      limited = 16'(32'($signed(rate_sp_q)) + rate_step(opening_rate_limit_q));
    end else if (delta < 0 && closing_rate_limit_q != 16'h0000
        && -delta > rate_step(closing_rate_limit_q)) begin
      limited = 16'(32'($signed(rate_sp_q)) - rate_step(closing_rate_limit_q));
    end
  end

  // the limiter state keeps tracking while a cutoff holds the target saturated,
  // so the target resumes from a current value once travel leaves the cutoff zone;
  // the upper cutoff wins if both zones overlap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rate_sp_q <= 16'h0000;
      target_q  <= 16'h0000;
    end else if (tick_q) begin
      rate_sp_q <= limited;
      if (cutoff_en_q[CUT_UPPER_BIT]
          && $signed(travel) > $signed(upper_saturation_threshold_q)) begin
        target_q <= TARGET_HIGH_SAT;
      end else if (cutoff_en_q[CUT_LOWER_BIT]
                   && $signed(travel) < $signed(lower_saturation_threshold_q)) begin
        target_q <= TARGET_LOW_SAT;
      end else begin
        target_q <= limited;
      end
    end
  end

  // read mux, one cycle latency; unmapped reads zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd) begin
      unique case (addr)
        OFS_OPEN_RATE:   rdata_q <= {16'h0, opening_rate_limit_q};
        OFS_CLOSE_RATE:  rdata_q <= {16'h0, closing_rate_limit_q};
        OFS_LAG_TIME:    rdata_q <= {24'h0, lag_time_q};
        OFS_CUTOFF_CTRL: rdata_q <= {30'h0, cutoff_en_q};
        OFS_UPPER_THR:   rdata_q <= {16'h0, upper_saturation_threshold_q};
        OFS_LOWER_THR:   rdata_q <= {16'h0, lower_saturation_threshold_q};
        OFS_TUNE_SEL:    rdata_q <= {26'h0, table_q, tune_set_q};
        OFS_PROP_GAIN:   rdata_q <= {16'h0, prop_q};
        OFS_VEL_GAIN:    rdata_q <= {16'h0, vel_q};
        OFS_IFB_GAIN:    rdata_q <= {24'h0, ifb_q};
        OFS_SETPOINT:    rdata_q <= {16'h0, setpoint_q};
        OFS_TARGET:      rdata_q <= {16'h0, target_q};
        OFS_TRAVEL:      rdata_q <= {16'h0, travel};
        default:         rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign rdata                    = rdata_q;
  assign travel_target            = target_q;
  assign prop_gain                = prop_q;
  assign vel_gain                 = vel_q;
  assign inner_loop_feedback_gain = ifb_q;
  assign update_pulse             = tick_q;
endmodule : setpoint_conditioner
`default_nettype wire

/* verif/spc_checker_assertions.sv */
// spc_checker: port-level properties of the set-point conditioner
// assumes one clock domain, bound onto every conditioner instance
`timescale 1ns/100ps
`default_nettype none
module spc_checker
  import spc_pkg::*;
#(
  parameter int UPD_CYCLES = UPDATE_CYCLES
)(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [15:0] travel,
  input wire logic [15:0] travel_target,
  input wire logic [15:0] prop_gain,
  input wire logic [15:0] vel_gain,
  input wire logic [7:0]  inner_loop_feedback_gain,
  input wire logic        update_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic        [15:0] open_q, close_q, up_q, lo_q, prev_q;
  logic        [1:0]  cut_q;
  logic               seen_q;
  int                 cnt_q;
  logic        [15:0] ostep, cstep;
  logic signed [16:0] delta;

  // mirror of the configuration written over the register port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      open_q <= 16'h0000;
      close_q <= 16'h0000;
      cut_q <= 2'h0;
      up_q <= THR_RESET;
      lo_q <= THR_RESET;
    end else if (wr) begin
      if (addr == OFS_OPEN_RATE) open_q <= wdata[15:0];
      if (addr == OFS_CLOSE_RATE) close_q <= wdata[15:0];
      if (addr == OFS_CUTOFF_CTRL) cut_q <= wdata[1:0];
      if (addr == OFS_UPPER_THR) up_q <= wdata[15:0];
      if (addr == OFS_LOWER_THR) lo_q <= wdata[15:0];
    end
  end

  // cycles since the last update and the previous target
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 0;
      seen_q <= 1'b0;
      prev_q <= 16'h0000;
    end else begin
      cnt_q <= update_pulse ? 0 : cnt_q + 1;
      seen_q <= seen_q | update_pulse;
      prev_q <= travel_target;
    end
  end

  // per-update step, at least one unit when a rate is set
  assign ostep = (open_q / UPDATE_HZ == 0) ? 16'h0001 : 16'(open_q / UPDATE_HZ);
  assign cstep = (close_q / UPDATE_HZ == 0) ? 16'h0001 : 16'(close_q / UPDATE_HZ);
  assign delta = {travel_target[15], travel_target} - {prev_q[15], prev_q};

  a_pulse_single: assert property (update_pulse |=> !update_pulse)
    else $error("update pulse longer than one cycle");
  a_pulse_period: assert property (update_pulse && seen_q |-> cnt_q == UPD_CYCLES - 1)
    else $error("update period wrong");
  a_target_hold: assert property (!update_pulse |=> $stable(travel_target))
    else $error("target moved outside an update");
  a_open_rate: assert property (update_pulse && open_q != 0 && cut_q == 0
    |=> delta <= $signed({1'b0, ostep}))
    else $error("opening step too large");
  a_close_rate: assert property (update_pulse && close_q != 0 && cut_q == 0
    |=> delta >= -$signed({1'b0, cstep}))
    else $error("closing step too large");
  a_upper_cutoff: assert property (update_pulse && cut_q[0] && $signed(travel) > $signed(up_q)
    |=> travel_target == TARGET_HIGH_SAT)
    else $error("upper cutoff not applied");
  a_lower_cutoff: assert property (update_pulse && cut_q[1] && $signed(travel) < $signed(lo_q)
    && !(cut_q[0] && $signed(travel) > $signed(up_q)) |=> travel_target == TARGET_LOW_SAT)
    else $error("lower cutoff not applied");

  // a gain written at one edge shows on its output two edges later
  property p_gain_w(logic [7:0] ofs, logic [15:0] g, logic [15:0] m);
    wr && addr == ofs |-> ##2 g == ($past(wdata[15:0], 2) & m);
  endproperty
  a_prop_write: assert property (p_gain_w(OFS_PROP_GAIN, prop_gain, 16'hFFFF))
    else $error("proportional gain write not applied");
  a_vel_write: assert property (p_gain_w(OFS_VEL_GAIN, vel_gain, 16'hFFFF))
    else $error("velocity gain write not applied");
  a_ifb_write: assert property (p_gain_w(OFS_IFB_GAIN, {8'h00, inner_loop_feedback_gain},
    16'h00FF))
    else $error("feedback gain write not applied");

  c_cutoff: cover property (update_pulse && cut_q != 0);
  c_select: cover property (wr && addr == OFS_TUNE_SEL);
  c_read: cover property (rd);
endmodule : spc_checker

bind setpoint_conditioner spc_checker #(.UPD_CYCLES(UPD_CYCLES)) u_chk (.clk(clk),
  .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .travel(travel), .travel_target(travel_target), .prop_gain(prop_gain),
  .vel_gain(vel_gain), .inner_loop_feedback_gain(inner_loop_feedback_gain),
  .update_pulse(update_pulse));
`default_nettype wire

/* verif/testbench.sv */
// testbench: register-port sequences for the set-point conditioner
// assumes a 20 MHz clock and a short update period for simulation
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module testbench
  import spc_pkg::*;
;
  logic        clk, arst_n, wr, rd, update_pulse;
  logic [7:0]  addr, ifb;
  logic [31:0] wdata, rdata, d;
  logic [15:0] travel, target, prop, vel;
  int          n_fail, cmp_count, cyc;
  localparam logic [15:0] PT [11] = '{16'h01B8, 16'h01E0, 16'h0226, 16'h026C, 16'h02D0,
    16'h0348, 16'h03CA, 16'h046A, 16'h051E, 16'h060E, 16'h0708};
  localparam logic [15:0] VT [11] = '{16'h012C, 16'h012C, 16'h012C, 16'h0136, 16'h0168,
    16'h01A4, 16'h01E5, 16'h0235, 16'h0258, 16'h0258, 16'h0258};
  localparam logic [7:0] FT [11] = '{8'h23, 8'h23, 8'h23, 8'h23, 8'h22, 8'h1F, 8'h1B,
    8'h17, 8'h12, 8'h0C, 8'h0C};
  localparam logic [7:0] HS [4] = '{8'h10, 8'h1A, 8'h20, 8'h2A};
  localparam logic [15:0] HP [4] = '{16'h00AA, 16'h02EE, 16'h00FA, 16'h03E8};

  setpoint_conditioner #(.UPD_CYCLES(20)) DUT (.clk(clk), .arst_n(arst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .travel(travel),
    .travel_target(target), .prop_gain(prop), .vel_gain(vel),
    .inner_loop_feedback_gain(ifb), .update_pulse(update_pulse));

  // clock generation
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic report_and_stop;
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // two writes on consecutive cycles, no idle cycle between them
  task automatic wr_pair(input logic [7:0] a0, input logic [31:0] v0,
                         input logic [7:0] a1, input logic [31:0] v1);
    @(posedge clk);
    addr <= a0;
    wdata <= v0;
    wr <= 1'b1;
    @(posedge clk);
    addr <= a1;
    wdata <= v1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_pair

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd_reg

  // waits for an update, returns just after the target has moved
  task automatic wait_upd;
    int k;
    for (k = 0; k < 100; k++) begin
      @(negedge clk);
      if (update_pulse === 1'b1) break;
    end
    if (k == 100) `CHK(update_pulse, 1'b1)
    @(posedge clk);
    #1;
  endtask : wait_upd

  task automatic sel_settle(input logic [31:0] v);
    wr_reg(OFS_TUNE_SEL, v);
    repeat (3) @(posedge clk);
    #1;
  endtask : sel_settle

  // main sequence
  initial begin
    arst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    travel = 16'h09C4;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(OFS_UPPER_THR, d);
    `CHK(d[15:0], THR_RESET)
    rd_reg(OFS_LOWER_THR, d);
    `CHK(d[15:0], THR_RESET)
    rd_reg(8'h3C, d);
    `CHK(d, 32'h0)
    rd_reg(OFS_TRAVEL, d);
    `CHK(d[15:0], travel)
    wr_reg(OFS_LAG_TIME, 32'h0);
    wr_reg(OFS_CUTOFF_CTRL, 32'h0);
    wr_reg(OFS_OPEN_RATE, 32'h2710);
    wr_reg(OFS_CLOSE_RATE, 32'h1388);
    wait_upd();
    wr_reg(OFS_SETPOINT, 32'h03E8);
    wait_upd();
    `CHK(target, 16'h0064)
    wait_upd();
    `CHK(target, 16'h00C8)
    wr_reg(OFS_SETPOINT, 32'hFFFFFC18);
    wait_upd();
    `CHK(target, 16'h0096)
    wr_reg(OFS_OPEN_RATE, 32'h0);
    wr_reg(OFS_CLOSE_RATE, 32'h0);
    wr_reg(OFS_SETPOINT, 32'h0BB8);
    wait_upd();
    `CHK(target, 16'h0BB8)
    wr_reg(OFS_SETPOINT, 32'hF830);
    wait_upd();
    `CHK(target, 16'hF830)
    wr_reg(OFS_LAG_TIME, 32'h0A);
    wr_reg(OFS_SETPOINT, 32'h07D0);
    wait_upd();
    `CHK(target, 16'hF858)
    wr_reg(OFS_LAG_TIME, 32'h01);
    rd_reg(OFS_LAG_TIME, d);
    `CHK(d[7:0], LAG_MIN)
    wr_reg(OFS_LAG_TIME, 32'h0);
    wait_upd();
    `CHK(target, 16'h07D0)
    wr_reg(OFS_CUTOFF_CTRL, 32'h1);
    travel <= 16'h1770;
    wait_upd();
    `CHK(target, TARGET_HIGH_SAT)
    travel <= 16'h1388;
    wait_upd();
    `CHK(target, 16'h07D0)
    wr_reg(OFS_CUTOFF_CTRL, 32'h2);
    travel <= 16'h0FA0;
    wait_upd();
    `CHK(target, TARGET_LOW_SAT)
    travel <= 16'h1388;
    wait_upd();
    `CHK(target, 16'h07D0)
    wr_reg(OFS_UPPER_THR, 32'h1F40);
    wr_reg(OFS_CUTOFF_CTRL, 32'h3);
    travel <= 16'h1B58;
    wait_upd();
    `CHK(target, 16'h07D0)
    for (int i = 0; i < 11; i++) begin
      sel_settle(i);
      `CHK(prop, PT[i])
      `CHK(vel, VT[i])
      `CHK(ifb, FT[i])
    end
    for (int i = 0; i < 4; i++) begin
      sel_settle(HS[i]);
      `CHK(prop, HP[i])
      `CHK(ifb, 8'h00)
    end
    sel_settle(32'hA);
    wr_reg(OFS_PROP_GAIN, 32'h01F4);
    rd_reg(OFS_TUNE_SEL, d);
    `CHK(d[3:0], SET_EXPERT)
    `CHK(prop, 16'h01F4)
    wr_pair(OFS_VEL_GAIN, 32'h0309, OFS_IFB_GAIN, 32'h14);
    repeat (3) @(posedge clk);
    #1;
    `CHK(prop, 16'h01F4)
    `CHK(vel, 16'h0309)
    `CHK(ifb, 8'h14)
    sel_settle(32'h0);
    `CHK(prop, 16'h01B8)
    wr_reg(OFS_CMD, 32'h1);
    rd_reg(OFS_TUNE_SEL, d);
    `CHK(d[3:0], SET_EXPERT)
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
